// ===== logic/fcwd_pkg.sv
// Constants, register map and carrier types of the fieldbus comm watchdog.
// Assumes a 100 MHz clock and one 16-bit register access at a time.
//
// Overview of operation
// - A stop key in the stop register stops the watchdog and clears faults.
// - Close option equal to 1 closes the MODBUS socket on timeout.
// - On timeout every process output is forced to zero.
// - Outputs resume normal operation once communication is re-established.
// - Alternative flag and timeout value are kept in non-volatile storage.
// - Timeout value writes are rejected while the watchdog runs.
// - Each register is one 16-bit word; each access moves one word.
// - Timeout value counts in units of 100 milliseconds.
// - Mask bit n-1 enables function code n as trigger, codes 1 to 16.
// - Enabled requests restart the count; a gap over timeout raises timeout.
// - Nonzero changed trigger write starts, retriggers and clears the fault.
// - A save key makes timeout, mask and third parameter non-volatile.
// - State register reads 0 inactive, 1 running, 2 expired.
package fcwd_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [15:0] ADDR_TIMEOUT = 16'h1000;
    localparam logic [15:0] ADDR_MASK = 16'h1001;
    localparam logic [15:0] ADDR_PARAM3 = 16'h1002;
    localparam logic [15:0] ADDR_TRIGGER = 16'h1003;
    localparam logic [15:0] ADDR_STATE = 16'h1006;
    localparam logic [15:0] ADDR_STOP = 16'h1008;
    localparam logic [15:0] ADDR_CLOSE = 16'h1009;
    localparam logic [15:0] ADDR_ALT = 16'h100A;
    localparam logic [15:0] ADDR_SAVE = 16'h100B;

    localparam logic [15:0] KEY_A = 16'hAA55;
    localparam logic [15:0] KEY_B = 16'h55AA;
    localparam logic [15:0] ALT_ARM_VALUE = 16'h0001;
    localparam logic [15:0] CLOSE_ON_VALUE = 16'h0001;

    localparam logic [15:0] RST_TIMEOUT = 16'h0000;
    localparam logic [15:0] RST_MASK = 16'h0000;
    localparam logic [15:0] RST_PARAM3 = 16'h0000;
    localparam logic [15:0] RST_TRIGGER = 16'h0000;
    localparam logic [15:0] RST_STOP = 16'h0000;
    localparam logic [15:0] RST_CLOSE = 16'h0000;
    localparam logic [15:0] RST_ALT = 16'h0000;

    localparam logic [15:0] CODE_INACTIVE = 16'h0000;
    localparam logic [15:0] CODE_RUNNING = 16'h0001;
    localparam logic [15:0] CODE_EXPIRED = 16'h0002;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } fcwd_req_s;

    typedef struct packed {
        logic [15:0] timeout;
        logic [15:0] mask;
        logic [15:0] param3;
        logic [15:0] alt;
    } fcwd_nv_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_RUN,
        ST_EXPIRED
    } fcwd_state_e;

endpackage

// ===== logic/fcwd_tick.sv
// Divider that emits a one-cycle enable pulse every tick period.
// Assumes clear restarts the period so a retrigger gets a full first tick.
`timescale 1ns/1ns
module fcwd_tick #(
    parameter int CYCLES = fcwd_pkg::TICK_CYCLES
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clear,
    output logic tick
);

    logic [23:0] cnt_q;
    logic [23:0] cnt_d;
    logic tick_q;
    logic tick_d;

    always_comb
    begin
        cnt_d = cnt_q + 24'h000001;
        tick_d = 1'b0;
        if (clear)
        begin
            cnt_d = 24'h000000;
        end
        else if (cnt_q == 24'(CYCLES - 1))
        begin
            cnt_d = 24'h000000;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cnt_q <= 24'h000000;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

endmodule

// ===== logic/fcwd_top.sv
// Communication watchdog with its 16-bit register file and request monitor.
// Assumes one register access per req_valid pulse and that the non-volatile
// store outside keeps nv_image on nv_save and returns it on nv_restore.
`timescale 1ns/1ns
module fcwd_top #(
    parameter int TICK_CYCLES = fcwd_pkg::TICK_CYCLES
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic req_valid,
    input fcwd_pkg::fcwd_req_s req,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    output logic rsp_error,
    input wire logic mb_req_valid,
    input wire logic [7:0] mb_func,
    input wire logic [15:0] proc_out_in,
    output logic [15:0] proc_out,
    output logic outputs_forced,
    output logic socket_close,
    output logic nv_save,
    output fcwd_pkg::fcwd_nv_s nv_image,
    input fcwd_pkg::fcwd_nv_s nv_restore
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic is_key(input logic [15:0] v);
        is_key = (v == fcwd_pkg::KEY_A) || (v == fcwd_pkg::KEY_B);
    endfunction

    function automatic logic fc_enabled(input logic [15:0] mask,
                                        input logic [7:0] fc);
        fc_enabled = 1'b0;
        if (fc >= 8'h01 && fc <= 8'h10)
        begin
            fc_enabled = mask[4'(fc - 8'h01)];
        end
    endfunction

    function automatic logic [15:0] state_code(input fcwd_pkg::fcwd_state_e s);
        case (s)
            fcwd_pkg::ST_RUN: state_code = fcwd_pkg::CODE_RUNNING;
            fcwd_pkg::ST_EXPIRED: state_code = fcwd_pkg::CODE_EXPIRED;
            default: state_code = fcwd_pkg::CODE_INACTIVE;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    fcwd_pkg::fcwd_state_e state_q, state_d;
    fcwd_pkg::fcwd_nv_s par_q, par_d;
    logic [15:0] trig_q, trig_d;
    logic [15:0] stop_q, stop_d;
    logic [15:0] close_q, close_d;
    logic [15:0] cnt_q, cnt_d;
    logic restored_q;
    logic rsp_valid_q, rsp_valid_d;
    logic [15:0] rdata_q, rdata_d;
    logic err_q, err_d;
    logic sock_q, sock_d;
    logic save_q, save_d;
    logic [15:0] pout_q, pout_d;
    logic tick;
    logic restart;
    logic wr;
    logic alt_mode;

    assign wr = req_valid && req.write;
    assign alt_mode = (par_q.alt == fcwd_pkg::ALT_ARM_VALUE);

    fcwd_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .reset(reset),
        .clear(restart),
        .tick(tick)
    );

    // ----------------------------------------------------------------
    // Next-state and register file
    // ----------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        par_d = par_q;
        trig_d = trig_q;
        stop_d = stop_q;
        close_d = close_q;
        cnt_d = cnt_q;
        restart = 1'b0;
        rsp_valid_d = req_valid;
        rdata_d = 16'h0000;
        err_d = 1'b0;
        save_d = 1'b0;
        sock_d = 1'b0;

        // Timer: one count per 100 ms tick, saturating.
        if (state_q == fcwd_pkg::ST_RUN && tick)
        begin
            if (cnt_q >= par_q.timeout)
            begin
                state_d = fcwd_pkg::ST_EXPIRED;
                sock_d = (close_q == fcwd_pkg::CLOSE_ON_VALUE);
            end
            else
            begin
                cnt_d = cnt_q + 16'h0001;
            end
        end

        // Request monitor.
        if (mb_req_valid)
        begin
            if (alt_mode && state_q != fcwd_pkg::ST_IDLE)
            begin
                state_d = fcwd_pkg::ST_RUN;
                restart = 1'b1;
            end
            else if (!alt_mode && state_q != fcwd_pkg::ST_IDLE
                     && fc_enabled(par_q.mask, mb_func))
            begin
                state_d = fcwd_pkg::ST_RUN;
                restart = 1'b1;
            end
        end

        // Single-word register access.
        if (req_valid)
        begin
            case (req.addr)
                fcwd_pkg::ADDR_TIMEOUT: rdata_d = par_q.timeout;
                fcwd_pkg::ADDR_MASK: rdata_d = par_q.mask;
                fcwd_pkg::ADDR_PARAM3: rdata_d = par_q.param3;
                fcwd_pkg::ADDR_TRIGGER: rdata_d = trig_q;
                fcwd_pkg::ADDR_STATE: rdata_d = state_code(state_q);
                fcwd_pkg::ADDR_STOP: rdata_d = stop_q;
                fcwd_pkg::ADDR_CLOSE: rdata_d = close_q;
                fcwd_pkg::ADDR_ALT: rdata_d = par_q.alt;
                fcwd_pkg::ADDR_SAVE: rdata_d = 16'h0000;
                default: err_d = 1'b1;
            endcase
        end

        if (wr)
        begin
            case (req.addr)
                fcwd_pkg::ADDR_TIMEOUT:
                begin
                    if (state_q == fcwd_pkg::ST_RUN)
                    begin
                        err_d = 1'b1;
                    end
                    else
                    begin
                        par_d.timeout = req.wdata;
                        save_d = 1'b1;
                    end
                end
                fcwd_pkg::ADDR_MASK:
                begin
                    par_d.mask = req.wdata;
                    if (req.wdata != 16'h0000
                        && state_q == fcwd_pkg::ST_IDLE && !alt_mode)
                    begin
                        state_d = fcwd_pkg::ST_RUN;
                        restart = 1'b1;
                    end
                end
                fcwd_pkg::ADDR_PARAM3: par_d.param3 = req.wdata;
                fcwd_pkg::ADDR_TRIGGER:
                begin
                    trig_d = req.wdata;
                    if (req.wdata != 16'h0000 && req.wdata != trig_q)
                    begin
                        state_d = fcwd_pkg::ST_RUN;
                        restart = 1'b1;
                    end
                end
                fcwd_pkg::ADDR_STOP:
                begin
                    stop_d = req.wdata;
                    if (is_key(req.wdata))
                    begin
                        state_d = fcwd_pkg::ST_IDLE;
                        restart = 1'b1;
                    end
                end
                fcwd_pkg::ADDR_CLOSE: close_d = req.wdata;
                fcwd_pkg::ADDR_ALT:
                begin
                    par_d.alt = req.wdata;
                    save_d = 1'b1;
                    if (req.wdata == fcwd_pkg::ALT_ARM_VALUE
                        && state_q == fcwd_pkg::ST_IDLE)
                    begin
                        state_d = fcwd_pkg::ST_ARMED;
                    end
                end
                fcwd_pkg::ADDR_SAVE: save_d = is_key(req.wdata);
                default: err_d = 1'b1;
            endcase
        end

        // A restart wins over a tick in the same cycle.
        if (restart)
        begin
            cnt_d = 16'h0000;
            sock_d = 1'b0;
        end

        // Stored parameters come back once, just after reset release.
        if (!restored_q)
        begin
            par_d = nv_restore;
        end
    end

    // Outputs track the process image unless the watchdog has expired.
    always_comb
    begin
        pout_d = proc_out_in;
        if (state_d == fcwd_pkg::ST_EXPIRED)
        begin
            pout_d = 16'h0000;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_q <= fcwd_pkg::ST_IDLE;
            par_q <= '{fcwd_pkg::RST_TIMEOUT, fcwd_pkg::RST_MASK,
                       fcwd_pkg::RST_PARAM3, fcwd_pkg::RST_ALT};
            trig_q <= fcwd_pkg::RST_TRIGGER;
            stop_q <= fcwd_pkg::RST_STOP;
            close_q <= fcwd_pkg::RST_CLOSE;
            cnt_q <= 16'h0000;
            restored_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rdata_q <= 16'h0000;
            err_q <= 1'b0;
            sock_q <= 1'b0;
            save_q <= 1'b0;
            pout_q <= 16'h0000;
        end
        else
        begin
            state_q <= state_d;
            par_q <= par_d;
            trig_q <= trig_d;
            stop_q <= stop_d;
            close_q <= close_d;
            cnt_q <= cnt_d;
            restored_q <= 1'b1;
            rsp_valid_q <= rsp_valid_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
            sock_q <= sock_d;
            save_q <= save_d;
            pout_q <= pout_d;
        end
    end

    assign rsp_valid = rsp_valid_q;
    assign rsp_rdata = rdata_q;
    assign rsp_error = err_q;
    assign proc_out = pout_q;
    assign outputs_forced = (state_q == fcwd_pkg::ST_EXPIRED);
    assign socket_close = sock_q;
    assign nv_save = save_q;
    assign nv_image = par_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_stop_key_idle: assert property (@(posedge clk) disable iff (reset)
        wr && req.addr == fcwd_pkg::ADDR_STOP && is_key(req.wdata)
        |=> state_q == fcwd_pkg::ST_IDLE && !outputs_forced)
        else $error("stop key did not stop the watchdog");
    a_close_socket: assert property (@(posedge clk) disable iff (reset)
        $rose(outputs_forced) |-> socket_close ==
        ($past(close_q) == fcwd_pkg::CLOSE_ON_VALUE))
        else $error("socket close does not follow the close option");
    a_alt_first_req: assert property (@(posedge clk) disable iff (reset)
        state_q == fcwd_pkg::ST_ARMED && mb_req_valid && alt_mode
        && !wr |=> state_q == fcwd_pkg::ST_RUN)
        else $error("armed watchdog did not start on request");
    a_alt_restart: assert property (@(posedge clk) disable iff (reset)
        state_q == fcwd_pkg::ST_RUN && alt_mode && mb_req_valid && !wr
        |=> cnt_q == 16'h0000 ##1 cnt_q == 16'h0000)
        else $error("request did not restart the count");
    a_force_zero: assert property (@(posedge clk) disable iff (reset)
        state_q == fcwd_pkg::ST_EXPIRED && restored_q
        |-> proc_out == 16'h0000)
        else $error("outputs not forced to zero after timeout");
    a_resume_out: assert property (@(posedge clk) disable iff (reset)
        state_q == fcwd_pkg::ST_EXPIRED && wr
        && req.addr == fcwd_pkg::ADDR_TRIGGER && req.wdata != 16'h0000
        && req.wdata != trig_q |=> proc_out == $past(proc_out_in))
        else $error("outputs did not resume after retrigger");
    a_nv_on_alt: assert property (@(posedge clk) disable iff (reset)
        wr && req.addr == fcwd_pkg::ADDR_ALT
        |=> nv_save && nv_image.alt == $past(req.wdata))
        else $error("alternative flag not saved");
    a_tmo_locked: assert property (@(posedge clk) disable iff (reset)
        state_q == fcwd_pkg::ST_RUN && wr
        && req.addr == fcwd_pkg::ADDR_TIMEOUT && restored_q
        |=> $stable(par_q.timeout) && rsp_error)
        else $error("timeout changed while running");
    a_read_latency: assert property (@(posedge clk) disable iff (reset)
        req_valid |=> rsp_valid)
        else $error("register access not answered");

    a_mask_restart: assert property (@(posedge clk) disable iff (reset)
        state_q == fcwd_pkg::ST_RUN && !alt_mode && mb_req_valid && !wr
        && mb_func == 8'h05 && par_q.mask[4] |=> cnt_q == 16'h0000)
        else $error("enabled function code did not restart");

    a_expire_tick: assert property (@(posedge clk) disable iff (reset)
        state_q == fcwd_pkg::ST_RUN && tick && cnt_q >= par_q.timeout
        && !restart |=> state_q == fcwd_pkg::ST_EXPIRED)
        else $error("watchdog missed its timeout");

    a_state_code: assert property (@(posedge clk) disable iff (reset)
        req_valid && !req.write && req.addr == fcwd_pkg::ADDR_STATE
        |=> rsp_rdata == state_code($past(state_q)))
        else $error("state register reads wrong code");

endmodule

// ===== testbench/fcwd_client_model.sv
// Behavioural MODBUS/TCP client that sends request pulses to the watchdog.
// Assumes the bench calls one task at a time and that clk is free running.
`timescale 1ns/1ns
module fcwd_client_model
(
    input wire logic clk,
    output logic mb_req_valid,
    output logic [7:0] mb_func
);
    initial
    begin
        mb_req_valid = 1'b0;
        mb_func = 8'h00;
    end

    // ----------------------------------------------------------------
    // Requests
    // ----------------------------------------------------------------
    // The code line is inverted between requests so that a stale code
    // cannot pass for a valid one.
    task automatic send(input logic [7:0] fc);
        @(posedge clk);
        mb_req_valid <= 1'b1;
        mb_func <= fc;
        @(posedge clk);
        mb_req_valid <= 1'b0;
        mb_func <= ~fc;
    endtask

    // A polling client: n requests, each gap plus 2 cycles after the one before.
    task automatic poll(input logic [7:0] fc, input int gap, input int n);
        repeat (n)
        begin
            send(fc);
            repeat (gap) @(posedge clk);
        end
    endtask
endmodule

// ===== testbench/fcwd_top_tb.sv
// Self-checking bench for the watchdog top with a short tick period.
// Assumes the client model in fcwd_client_model.sv is compiled first.
`timescale 1ns/1ns
module fcwd_top_tb;
    localparam int TK = 10;
    logic clk;
    logic reset;
    logic req_valid;
    fcwd_pkg::fcwd_req_s req;
    logic rsp_valid;
    logic [15:0] rsp_rdata;
    logic rsp_error;
    logic mb_req_valid;
    logic [7:0] mb_func;
    logic [15:0] proc_out_in;
    logic [15:0] proc_out;
    logic outputs_forced;
    logic socket_close;
    logic nv_save;
    fcwd_pkg::fcwd_nv_s nv_image;
    fcwd_pkg::fcwd_nv_s nv_restore;
    int n_errors;
    int checked;
    int n_close;
    int n_save;
    int s;
    logic [15:0] rd;
    logic er;

    fcwd_top #(.TICK_CYCLES(TK)) DUT (.clk(clk), .reset(reset),
        .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_error(rsp_error),
        .mb_req_valid(mb_req_valid), .mb_func(mb_func),
        .proc_out_in(proc_out_in), .proc_out(proc_out),
        .outputs_forced(outputs_forced), .socket_close(socket_close),
        .nv_save(nv_save), .nv_image(nv_image), .nv_restore(nv_restore));

    fcwd_client_model u_cli (.clk(clk), .mb_req_valid(mb_req_valid),
        .mb_func(mb_func));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (socket_close === 1'b1)
            n_close++;
        if (nv_save === 1'b1)
            n_save++;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("Errors %0d, checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One word per access; the answer stands in the cycle after the take.
    task automatic bus(input logic w, input logic [15:0] a,
                       input logic [15:0] d);
        @(posedge clk);
        req_valid <= 1'b1;
        req <= {w, a, d};
        @(posedge clk);
        req_valid <= 1'b0;
        #1;
        chk({15'h0000, rsp_valid}, 16'h0001);
        rd = rsp_rdata;
        er = rsp_error;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
        bus(1'b0, a, 16'h0000);
        chk(rd, exp);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        rdchk(fcwd_pkg::ADDR_TIMEOUT, 16'h0002);
        rdchk(fcwd_pkg::ADDR_PARAM3, 16'h0033);
        rdchk(fcwd_pkg::ADDR_STATE, fcwd_pkg::CODE_INACTIVE);
        rdchk(fcwd_pkg::ADDR_STOP, fcwd_pkg::RST_STOP);
        rdchk(fcwd_pkg::ADDR_SAVE, 16'h0000);
        bus(1'b0, 16'h1007, 16'h0000);
        chk({15'h0000, er}, 16'h0001);
        chk(proc_out, proc_out_in);
    endtask

    // Each code must retrigger through its own mask bit.
    task automatic t_codes;
        for (int fc = 1; fc <= 16; fc++)
        begin
            wr(fcwd_pkg::ADDR_MASK, 16'h0001 << (fc - 1));
            repeat (20) @(posedge clk);
            u_cli.send(8'(fc));
            repeat (20) @(posedge clk);
            rdchk(fcwd_pkg::ADDR_STATE, fcwd_pkg::CODE_RUNNING);
            wr(fcwd_pkg::ADDR_STOP, fcwd_pkg::KEY_A);
        end
    endtask

    task automatic t_expire;
        wr(fcwd_pkg::ADDR_MASK, 16'h0010);
        wr(fcwd_pkg::ADDR_TIMEOUT, 16'h0005);
        chk({15'h0000, er}, 16'h0001);
        u_cli.send(8'h05);
        repeat (20) @(posedge clk);
        u_cli.send(8'h04);
        u_cli.send(8'h15);
        rdchk(fcwd_pkg::ADDR_STATE, fcwd_pkg::CODE_RUNNING);
        repeat (8) @(posedge clk);
        rdchk(fcwd_pkg::ADDR_STATE, fcwd_pkg::CODE_EXPIRED);
        chk(proc_out, 16'h0000);
        chk({15'h0000, outputs_forced}, 16'h0001);
        chk(16'(n_close), 16'h0000);
        wr(fcwd_pkg::ADDR_STOP, fcwd_pkg::KEY_A);
        rdchk(fcwd_pkg::ADDR_STATE, fcwd_pkg::CODE_INACTIVE);
        @(posedge clk);
        #1;
        chk(proc_out, proc_out_in);
        chk({15'h0000, outputs_forced}, 16'h0000);
        rdchk(fcwd_pkg::ADDR_TIMEOUT, 16'h0002);
    endtask

    task automatic t_trigger;
        wr(fcwd_pkg::ADDR_CLOSE, fcwd_pkg::CLOSE_ON_VALUE);
        wr(fcwd_pkg::ADDR_TRIGGER, 16'h0001);
        repeat (20) @(posedge clk);
        wr(fcwd_pkg::ADDR_TRIGGER, 16'h0002);
        repeat (20) @(posedge clk);
        rdchk(fcwd_pkg::ADDR_STATE, fcwd_pkg::CODE_RUNNING);
        wr(fcwd_pkg::ADDR_TRIGGER, 16'h0002);
        repeat (20) @(posedge clk);
        rdchk(fcwd_pkg::ADDR_STATE, fcwd_pkg::CODE_EXPIRED);
        chk(16'(n_close), 16'h0001);
        wr(fcwd_pkg::ADDR_TRIGGER, 16'h0003);
        rdchk(fcwd_pkg::ADDR_STATE, fcwd_pkg::CODE_RUNNING);
        chk({15'h0000, outputs_forced}, 16'h0000);
        wr(fcwd_pkg::ADDR_CLOSE, 16'h0002);
        wr(fcwd_pkg::ADDR_TRIGGER, 16'h0004);
        repeat (45) @(posedge clk);
        rdchk(fcwd_pkg::ADDR_STATE, fcwd_pkg::CODE_EXPIRED);
        chk(16'(n_close), 16'h0001);
        wr(fcwd_pkg::ADDR_STOP, fcwd_pkg::KEY_B);
        rdchk(fcwd_pkg::ADDR_STATE, fcwd_pkg::CODE_INACTIVE);
    endtask

    task automatic t_alt;
        s = n_save;
        wr(fcwd_pkg::ADDR_TIMEOUT, 16'h0002);
        wr(fcwd_pkg::ADDR_ALT, fcwd_pkg::ALT_ARM_VALUE);
        // The second save pulse is only counted one edge after the write.
        repeat (40) @(posedge clk);
        chk(16'(n_save - s), 16'h0002);
        chk(nv_image.alt, fcwd_pkg::ALT_ARM_VALUE);
        chk(nv_image.timeout, 16'h0002);
        rdchk(fcwd_pkg::ADDR_STATE, fcwd_pkg::CODE_INACTIVE);
        u_cli.poll(8'h17, 18, 3);
        rdchk(fcwd_pkg::ADDR_STATE, fcwd_pkg::CODE_RUNNING);
        repeat (30) @(posedge clk);
        rdchk(fcwd_pkg::ADDR_STATE, fcwd_pkg::CODE_EXPIRED);
        u_cli.send(8'h03);
        rdchk(fcwd_pkg::ADDR_STATE, fcwd_pkg::CODE_RUNNING);
        chk(proc_out, proc_out_in);
        wr(fcwd_pkg::ADDR_STOP, fcwd_pkg::KEY_A);
        wr(fcwd_pkg::ADDR_ALT, 16'h0000);
    endtask

    task automatic t_save;
        wr(fcwd_pkg::ADDR_PARAM3, 16'h0044);
        // Save pulses are counted one edge after the write is answered.
        s = n_save;
        wr(fcwd_pkg::ADDR_SAVE, 16'h1234);
        @(posedge clk);
        #1;
        chk(16'(n_save - s), 16'h0000);
        wr(fcwd_pkg::ADDR_SAVE, fcwd_pkg::KEY_B);
        wr(fcwd_pkg::ADDR_SAVE, fcwd_pkg::KEY_A);
        @(posedge clk);
        #1;
        chk(16'(n_save - s), 16'h0002);
        chk(nv_image.param3, 16'h0044);
        rdchk(fcwd_pkg::ADDR_SAVE, 16'h0000);
    endtask

    initial
    begin
        repeat (100000) @(posedge clk);
        n_errors++;
        close_out();
    end

    initial
    begin
        n_errors = 0;
        checked = 0;
        n_close = 0;
        n_save = 0;
        reset = 1'b1;
        req_valid = 1'b0;
        req = '0;
        proc_out_in = 16'hA5C3;
        nv_restore = {16'h0002, 16'h0000, 16'h0033, 16'h0000};
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset();
        t_codes();
        t_expire();
        t_trigger();
        t_alt();
        t_save();
        close_out();
    end
endmodule
